// ===== rtl/cws_pkg.sv
// Overview of operation
// - Once launched, fetch each step and apply its field write, in order, until last.
// - When the sequence finishes, stop stepping and report completion by an event.
// - A step may carry a wait, served after its write, before the next step.
// - Step timing is divided internally from the system clock; host keeps it running.
// - Unit enable is bit 5 of control one, reset 0; launches need it set.
// - Memory holds 128 steps of four registers each, addresses 4096 to 4607.
// - First-step index in control two bits 6:0; step n sits at 4096 plus 4n.
// - Writing 1 to launch bit 7 starts at the first index; cleared at end.
// - Writing 1 to cancel bit 8 ends the running sequence, returning control to host.
// - Running flag in control three bit 0 reads 1 while busy, 0 when idle.
// - While running, refuse general register accesses; sequencer control, reset and PLL stay open.
// - A refused host command is flagged so the I2C front end withholds its acknowledge.
// - Progress index in control three bits 9:3 shows latest step, kept after end.
// - At sequence end raise the finished event, meaning the sequencer is idle; cancel and enable drop end without it.
// - With auto-sequence bit 7 set, auto-mute runs sleep, unmute runs wake.
// - Step: 14-bit target, 8-bit value, 4-bit LSB, width code 0-7 for 1-8 bits.
// - Step time is k times (2 to the wait code plus 8), k by rate mode.
// - A step with its last flag set is the final one executed.
package cws_pkg;
  // Register map, 15-bit control addresses
  localparam logic [14:0] CTL_ONE_ADDR = 15'h0057;
  localparam logic [14:0] CTL_TWO_ADDR = 15'h005A;
  localparam logic [14:0] CTL_THREE_ADDR = 15'h005D;
  localparam logic [14:0] MEM_BASE_ADDR = 15'h1000;
  localparam logic [14:0] MEM_LAST_ADDR = 15'h11FF;
  localparam logic [15:0] CTL_RESET = 16'h0000;
  // Control field positions
  localparam int AUTOSEQ_BIT = 7;
  localparam int ENABLE_BIT = 5;
  localparam int CANCEL_BIT = 8;
  localparam int LAUNCH_BIT = 7;
  localparam int RUNNING_BIT = 0;
  localparam int PROGRESS_LSB = 3;
  // Step word layout inside the memory
  localparam int STEP_W = 34;
  localparam int TGT_LSB = 0;
  localparam int VAL_LSB = 14;
  localparam int CNT_LSB = 22;
  localparam int POS_LSB = 25;
  localparam int WAIT_LSB = 29;
  localparam int LAST_LSB = 33;
  // Field positions within the four host-visible step registers
  localparam int REG_CNT_LSB = 8;
  localparam int REG_LAST_BIT = 8;
  // Step time unit and derived cycle counts
  localparam int CLK_PERIOD_PS = 10000;
  localparam int K_INT_PS = 62500000;
  localparam int K_FRAC_PS = 68100000;
  localparam int K_INT_CYC = K_INT_PS / CLK_PERIOD_PS;
  localparam int K_FRAC_CYC = K_FRAC_PS / CLK_PERIOD_PS;
  localparam logic [15:0] WAIT_BASE = 16'h0008;
  typedef enum logic [1:0] {
    CWS_IDLE = 2'b00,
    CWS_FETCH = 2'b01,
    CWS_APPLY = 2'b10,
    CWS_WAIT = 2'b11
  } cws_phase_t;
endpackage

// ===== rtl/cws_step_mem.sv
`timescale 1ns/1ps
module cws_step_mem #(
  parameter int DEPTH = 128,
  parameter int WIDTH = cws_pkg::STEP_W
) (
  input wire logic mclk,
  input wire logic wr_en,
  input wire logic [$clog2(DEPTH)-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_mask,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [$clog2(DEPTH)-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem [DEPTH];
  // Masked write lets one host register touch only its own fields
  always_ff @(posedge mclk) begin
    if (wr_en) begin
      mem[wr_addr] <= (mem[wr_addr] & ~wr_mask) | (wr_data & wr_mask);
    end
    rd_data <= mem[rd_addr];
  end
endmodule // cws_step_mem

// ===== rtl/cws_tick_div.sv
`timescale 1ns/1ps
module cws_tick_div #(
  parameter int K_INT = cws_pkg::K_INT_CYC,
  parameter int K_FRAC = cws_pkg::K_FRAC_CYC
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic clr,
  input wire logic int_mode,
  output logic tick
);
  logic [15:0] cnt_r;
  logic [15:0] last;
  // Period follows the sample-rate mode
  assign last = int_mode ? 16'(K_INT - 1) : 16'(K_FRAC - 1);
  // Restarted per step so each step's time starts from a clean unit
  always_ff @(posedge mclk) begin
    if (rst || clr) begin
      cnt_r <= 16'h0000;
      tick <= 1'b0;
    end else begin
      tick <= (cnt_r == last);
      cnt_r <= (cnt_r == last) ? 16'h0000 : cnt_r + 16'h0001;
    end
  end
endmodule // cws_tick_div

// ===== rtl/cws_sequencer.sv
`timescale 1ns/1ps
module cws_sequencer #(
  parameter int K_INT = cws_pkg::K_INT_CYC,
  parameter int K_FRAC = cws_pkg::K_FRAC_CYC,
  parameter logic [14:0] SWRST_ADDR = 15'h0000,
  parameter logic [14:0] PLL_LO_ADDR = 15'h0080,
  parameter logic [14:0] PLL_HI_ADDR = 15'h00A0,
  parameter logic [6:0] SLEEP_IDX = 7'h00,
  parameter logic [6:0] WAKE_IDX = 7'h10
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic host_req,
  input wire logic host_we,
  input wire logic [14:0] host_addr,
  input wire logic [15:0] host_wdata,
  output logic host_resp,
  output logic host_hit,
  output logic host_refused,
  output logic [15:0] host_rdata,
  input wire logic int_rate_mode,
  input wire logic dac_automute,
  output logic reg_wr,
  output logic [13:0] reg_wr_addr,
  output logic [15:0] reg_wr_mask,
  output logic [15:0] reg_wr_data,
  output logic seq_running_flag,
  output logic seq_finished_event
);
  typedef struct packed {
    logic seq_unit_enable;
    logic automute_speaker_seq_enable;
    logic seq_launch;
    logic [6:0] seq_first_step_index;
    logic running;
    logic [6:0] seq_progress_index;
    cws_pkg::cws_phase_t phase;
    logic [15:0] wait_cnt;
    logic [15:0] wait_tgt;
    logic last_q;
    logic mute_q;
    logic pend_sleep;
    logic pend_wake;
    logic q_valid;
    logic q_hit;
    logic q_refused;
    logic [14:0] q_addr;
    logic resp;
    logic hit;
    logic refused;
    logic [15:0] rdata;
    logic wr;
    logic [13:0] wr_addr;
    logic [15:0] wr_mask;
    logic [15:0] wr_data;
    logic done;
  } cws_state_t;

  cws_state_t st_r;
  cws_state_t st_nxt;
  logic tick;
  logic div_clr;
  logic [cws_pkg::STEP_W-1:0] mem_rd;
  logic mem_we;
  logic [6:0] mem_wa;
  logic [cws_pkg::STEP_W-1:0] mem_wmask;
  logic [cws_pkg::STEP_W-1:0] mem_wdata;
  logic [6:0] mem_ra;
  logic is_ctl;
  logic is_mem;
  logic exempt;
  logic refuse_now;

  // Address classes of an incoming host command
  assign is_ctl = (host_addr == cws_pkg::CTL_ONE_ADDR) || (host_addr == cws_pkg::CTL_TWO_ADDR) ||
                  (host_addr == cws_pkg::CTL_THREE_ADDR);
  assign is_mem = (host_addr >= cws_pkg::MEM_BASE_ADDR) && (host_addr <= cws_pkg::MEM_LAST_ADDR);
  assign exempt = is_ctl || (host_addr == SWRST_ADDR) ||
                  ((host_addr >= PLL_LO_ADDR) && (host_addr <= PLL_HI_ADDR));
  // Memory is not exempt: its one read port is busy fetching steps
  assign refuse_now = host_req && st_r.running && !exempt;

  // Host step write: each of the four registers owns its own fields
  assign mem_we = host_req && host_we && is_mem && !st_r.running;
  assign mem_wa = host_addr[8:2];
  always_comb begin
    mem_wmask = '0;
    mem_wdata = '0;
    case (host_addr[1:0])
      2'b00: begin
        mem_wmask[cws_pkg::TGT_LSB +: 14] = 14'h3FFF;
        mem_wdata[cws_pkg::TGT_LSB +: 14] = host_wdata[13:0];
      end
      2'b01: begin
        mem_wmask[cws_pkg::VAL_LSB +: 8] = 8'hFF;
        mem_wdata[cws_pkg::VAL_LSB +: 8] = host_wdata[7:0];
      end
      2'b10: begin
        mem_wmask[cws_pkg::CNT_LSB +: 3] = 3'h7;
        mem_wmask[cws_pkg::POS_LSB +: 4] = 4'hF;
        mem_wdata[cws_pkg::CNT_LSB +: 3] = host_wdata[cws_pkg::REG_CNT_LSB +: 3];
        mem_wdata[cws_pkg::POS_LSB +: 4] = host_wdata[3:0];
      end
      default: begin
        mem_wmask[cws_pkg::WAIT_LSB +: 4] = 4'hF;
        mem_wmask[cws_pkg::LAST_LSB] = 1'b1;
        mem_wdata[cws_pkg::WAIT_LSB +: 4] = host_wdata[3:0];
        mem_wdata[cws_pkg::LAST_LSB] = host_wdata[cws_pkg::REG_LAST_BIT];
      end
    endcase
  end
  // The fetch owns the read port while running
  assign mem_ra = st_r.running ? st_r.seq_progress_index : host_addr[8:2];
  assign div_clr = (st_r.phase == cws_pkg::CWS_FETCH);

  cws_step_mem #(.DEPTH(128), .WIDTH(cws_pkg::STEP_W)) u_mem (
    .mclk(mclk),
    .wr_en(mem_we),
    .wr_addr(mem_wa),
    .wr_mask(mem_wmask),
    .wr_data(mem_wdata),
    .rd_addr(mem_ra),
    .rd_data(mem_rd)
  );

  cws_tick_div #(.K_INT(K_INT), .K_FRAC(K_FRAC)) u_div (
    .mclk(mclk),
    .rst(rst),
    .clr(div_clr),
    .int_mode(int_rate_mode),
    .tick(tick)
  );

  // Whole next state of the block
  always_comb begin
    logic [4:0] nbits;
    logic [3:0] pos;
    logic [23:0] wide_mask;
    logic [23:0] wide_data;
    logic start_host;
    logic start_auto;
    logic [6:0] auto_idx;
    logic wait_done;
    nbits = 5'h00;
    pos = 4'h0;
    wide_mask = 24'h000000;
    wide_data = 24'h000000;
    start_host = 1'b0;
    start_auto = 1'b0;
    auto_idx = WAKE_IDX;
    wait_done = 1'b0;
    st_nxt = st_r;
    st_nxt.wr = 1'b0;
    st_nxt.done = 1'b0;
    st_nxt.resp = 1'b0;
    st_nxt.mute_q = dac_automute;

    // Host control register writes, taken in the request cycle
    if (host_req && host_we && !refuse_now) begin
      if (host_addr == cws_pkg::CTL_ONE_ADDR) begin
        st_nxt.seq_unit_enable = host_wdata[cws_pkg::ENABLE_BIT];
        st_nxt.automute_speaker_seq_enable = host_wdata[cws_pkg::AUTOSEQ_BIT];
      end
      if (host_addr == cws_pkg::CTL_TWO_ADDR) begin
        st_nxt.seq_first_step_index = host_wdata[6:0];
        start_host = host_wdata[cws_pkg::LAUNCH_BIT] && st_r.seq_unit_enable && !st_r.running;
      end
    end

    // Queued speaker sequence starts only when idle and enabled
    if (!st_r.running && !start_host && st_r.seq_unit_enable && (st_r.pend_sleep || st_r.pend_wake)) begin
      start_auto = 1'b1;
      auto_idx = st_r.pend_sleep ? SLEEP_IDX : WAKE_IDX;
      st_nxt.pend_sleep = 1'b0;
      st_nxt.pend_wake = 1'b0;
    end
    // Auto-mute edges queue after the start, so a fresh edge is never lost
    if (st_r.automute_speaker_seq_enable && st_r.seq_unit_enable) begin
      if (dac_automute && !st_r.mute_q) begin
        st_nxt.pend_sleep = 1'b1;
        st_nxt.pend_wake = 1'b0;
      end else if (!dac_automute && st_r.mute_q) begin
        st_nxt.pend_wake = 1'b1;
        st_nxt.pend_sleep = 1'b0;
      end
    end

    // Step engine
    case (st_r.phase)
      cws_pkg::CWS_IDLE: begin
        if (start_host || start_auto) begin
          st_nxt.running = 1'b1;
          st_nxt.seq_launch = start_host;
          st_nxt.seq_progress_index = start_host ? host_wdata[6:0] : auto_idx;
          st_nxt.phase = cws_pkg::CWS_FETCH;
        end
      end
      cws_pkg::CWS_FETCH: begin
        st_nxt.phase = cws_pkg::CWS_APPLY;
      end
      cws_pkg::CWS_APPLY: begin
        // Partial write: only the selected bit span moves
        nbits = {2'b00, mem_rd[cws_pkg::CNT_LSB +: 3]} + 5'h01;
        pos = mem_rd[cws_pkg::POS_LSB +: 4];
        wide_mask = ((24'h000001 << nbits) - 24'h000001) << pos;
        wide_data = {16'h0000, mem_rd[cws_pkg::VAL_LSB +: 8]} << pos;
        st_nxt.wr = 1'b1;
        st_nxt.wr_addr = mem_rd[cws_pkg::TGT_LSB +: 14];
        st_nxt.wr_mask = wide_mask[15:0];
        st_nxt.wr_data = wide_data[15:0] & wide_mask[15:0];
        st_nxt.last_q = mem_rd[cws_pkg::LAST_LSB];
        // Time counts from the fetch and includes execution
        st_nxt.wait_tgt = (16'h0001 << mem_rd[cws_pkg::WAIT_LSB +: 4]) + cws_pkg::WAIT_BASE;
        st_nxt.wait_cnt = 16'h0000;
        st_nxt.phase = cws_pkg::CWS_WAIT;
      end
      cws_pkg::CWS_WAIT: begin
        if (tick) begin
          st_nxt.wait_cnt = st_r.wait_cnt + 16'h0001;
          wait_done = (st_r.wait_cnt + 16'h0001) >= st_r.wait_tgt;
        end
        if (wait_done) begin
          if (st_r.last_q) begin
            st_nxt.running = 1'b0;
            st_nxt.seq_launch = 1'b0;
            st_nxt.done = 1'b1;
            st_nxt.phase = cws_pkg::CWS_IDLE;
          end else begin
            st_nxt.seq_progress_index = st_r.seq_progress_index + 7'h01;
            st_nxt.phase = cws_pkg::CWS_FETCH;
          end
        end
      end
      default: begin
        st_nxt.phase = cws_pkg::CWS_IDLE;
      end
    endcase

    // Cancel, or enable dropped, ends at once with no wait served
    if (st_r.running && ((host_req && host_we && host_addr == cws_pkg::CTL_TWO_ADDR &&
        host_wdata[cws_pkg::CANCEL_BIT]) || !st_r.seq_unit_enable)) begin
      st_nxt.running = 1'b0;
      st_nxt.seq_launch = 1'b0;
      st_nxt.wr = 1'b0;
      st_nxt.phase = cws_pkg::CWS_IDLE;
    end

    // Request stage, answered one cycle later from registers
    st_nxt.q_valid = host_req;
    st_nxt.q_hit = is_ctl || is_mem;
    st_nxt.q_refused = refuse_now;
    st_nxt.q_addr = host_addr;
    if (st_r.q_valid) begin
      st_nxt.resp = 1'b1;
      st_nxt.hit = st_r.q_hit;
      st_nxt.refused = st_r.q_refused;
      st_nxt.rdata = cws_pkg::CTL_RESET;
      if (st_r.q_addr == cws_pkg::CTL_ONE_ADDR) begin
        st_nxt.rdata[cws_pkg::ENABLE_BIT] = st_r.seq_unit_enable;
        st_nxt.rdata[cws_pkg::AUTOSEQ_BIT] = st_r.automute_speaker_seq_enable;
      end else if (st_r.q_addr == cws_pkg::CTL_TWO_ADDR) begin
        st_nxt.rdata[6:0] = st_r.seq_first_step_index;
        st_nxt.rdata[cws_pkg::LAUNCH_BIT] = st_r.seq_launch;
      end else if (st_r.q_addr == cws_pkg::CTL_THREE_ADDR) begin
        st_nxt.rdata[cws_pkg::RUNNING_BIT] = st_r.running;
        st_nxt.rdata[cws_pkg::PROGRESS_LSB +: 7] = st_r.seq_progress_index;
      end else if (st_r.q_hit && !st_r.q_refused) begin
        case (st_r.q_addr[1:0])
          2'b00: st_nxt.rdata[13:0] = mem_rd[cws_pkg::TGT_LSB +: 14];
          2'b01: st_nxt.rdata[7:0] = mem_rd[cws_pkg::VAL_LSB +: 8];
          2'b10: begin
            st_nxt.rdata[cws_pkg::REG_CNT_LSB +: 3] = mem_rd[cws_pkg::CNT_LSB +: 3];
            st_nxt.rdata[3:0] = mem_rd[cws_pkg::POS_LSB +: 4];
          end
          default: begin
            st_nxt.rdata[cws_pkg::REG_LAST_BIT] = mem_rd[cws_pkg::LAST_LSB];
            st_nxt.rdata[3:0] = mem_rd[cws_pkg::WAIT_LSB +: 4];
          end
        endcase
      end
    end
  end

  // State register
  always_ff @(posedge mclk) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign host_resp = st_r.resp;
  assign host_hit = st_r.hit;
  assign host_refused = st_r.refused;
  assign host_rdata = st_r.rdata;
  assign reg_wr = st_r.wr;
  assign reg_wr_addr = st_r.wr_addr;
  assign reg_wr_mask = st_r.wr_mask;
  assign reg_wr_data = st_r.wr_data;
  assign seq_running_flag = st_r.running;
  assign seq_finished_event = st_r.done;

  // Checks on the sequencing
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  a_launch_needs_enable: assert property ($rose(st_r.running) |-> $past(st_r.seq_unit_enable))
    else $error("sequencer started while disabled");
  a_first_step_index: assert property ($rose(st_r.running) && st_r.seq_launch
    |-> st_r.seq_progress_index == $past(host_wdata[6:0]))
    else $error("launch did not start at first index");
  a_cancel_stops: assert property (host_req && host_we && host_addr == cws_pkg::CTL_TWO_ADDR
    && host_wdata[cws_pkg::CANCEL_BIT] && st_r.running |=> !st_r.running && !st_r.seq_launch)
    else $error("cancel did not stop the sequence");
  a_done_idle: assert property (seq_finished_event |-> !seq_running_flag && $past(st_r.running))
    else $error("finished event while still running");
  a_refuse_busy: assert property (host_req && st_r.running && !exempt |-> ##2 host_resp && host_refused)
    else $error("general access not refused while running");
  a_single_write: assert property (reg_wr |=> !reg_wr ##1 !reg_wr)
    else $error("step write not a single pulse");
  a_write_width: assert property (reg_wr |-> $countones(reg_wr_mask) <= 8
    && (reg_wr_data & ~reg_wr_mask) == 16'h0000)
    else $error("step write touches bits outside its span");
  a_wait_before_next: assert property (reg_wr |=> (st_r.phase == cws_pkg::CWS_WAIT || !st_r.running))
    else $error("step write not followed by its wait");
  a_last_stops: assert property (st_r.phase == cws_pkg::CWS_WAIT && st_r.last_q && tick
    && st_r.wait_cnt + 16'h0001 >= st_r.wait_tgt |=> !st_r.running && seq_finished_event)
    else $error("last step did not end the sequence");
  c_host_run: cover property ($rose(st_r.running) && st_r.seq_launch);
  c_done: cover property (seq_finished_event);
  c_cancel: cover property ($fell(st_r.running) && !seq_finished_event);
  c_auto_run: cover property ($rose(st_r.running) && !st_r.seq_launch);
endmodule // cws_sequencer

// ===== dv/cws_regfile_model.sv
`timescale 1ns/1ps
// Far side of the sequencer write port: a small bank of control registers
module cws_regfile_model (
  input wire logic mclk,
  input wire logic rst,
  input wire logic reg_wr,
  input wire logic [13:0] reg_wr_addr,
  input wire logic [15:0] reg_wr_mask,
  input wire logic [15:0] reg_wr_data,
  output int writes
);
  logic [15:0] regs [16];

  // Only masked bits change, so a slip in the mask shows up as corrupted neighbours
  always @(posedge mclk) begin
    if (rst) begin
      for (int k = 0; k < 16; k++) begin
        regs[k] <= 16'h0000;
      end
      writes <= 0;
    end else if (reg_wr) begin
      regs[reg_wr_addr[3:0]] <= (regs[reg_wr_addr[3:0]] & ~reg_wr_mask) | (reg_wr_data & reg_wr_mask);
      writes <= writes + 1;
    end
  end
endmodule // cws_regfile_model

// ===== dv/control_write_sequencer_test.sv
`timescale 1ns/1ps
module control_write_sequencer_test;
  logic mclk, rst, host_req, host_we, int_rate_mode, dac_automute;
  logic [14:0] host_addr;
  logic [15:0] host_wdata, host_rdata, reg_wr_mask, reg_wr_data, got_data;
  logic [13:0] reg_wr_addr;
  logic host_resp, host_hit, host_refused, reg_wr, seq_running_flag, seq_finished_event, got_ref, got_hit;
  int errors, num_checks, cyc, wr_cyc, wr_gap, fin_cnt, nwr;

  cws_sequencer #(.K_INT(4), .K_FRAC(5)) dut (.mclk(mclk), .rst(rst), .host_req(host_req), .host_we(host_we),
    .host_addr(host_addr), .host_wdata(host_wdata), .host_resp(host_resp), .host_hit(host_hit),
    .host_refused(host_refused), .host_rdata(host_rdata), .int_rate_mode(int_rate_mode),
    .dac_automute(dac_automute), .reg_wr(reg_wr), .reg_wr_addr(reg_wr_addr), .reg_wr_mask(reg_wr_mask),
    .reg_wr_data(reg_wr_data), .seq_running_flag(seq_running_flag), .seq_finished_event(seq_finished_event));
  cws_regfile_model model (.mclk(mclk), .rst(rst), .reg_wr(reg_wr), .reg_wr_addr(reg_wr_addr),
    .reg_wr_mask(reg_wr_mask), .reg_wr_data(reg_wr_data), .writes(nwr));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // Cycle count, spacing of sequencer writes, finished events
  always @(posedge mclk) begin
    cyc++;
    if (reg_wr === 1'b1) begin
      wr_gap = cyc - wr_cyc;
      wr_cyc = cyc;
    end
    if (seq_finished_event === 1'b1) fin_cnt++;
  end

  task tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One command; answer comes one cycle after the taking edge
  task cmd(input logic we, input logic [14:0] addr, input logic [15:0] data);
    int n;
    @(negedge mclk);
    host_req = 1'b1;
    host_we = we;
    host_addr = addr;
    host_wdata = data;
    @(negedge mclk);
    host_req = 1'b0;
    n = 0;
    while (host_resp !== 1'b1 && n < 4) begin
      @(negedge mclk);
      n++;
    end
    if (host_resp !== 1'b1) begin
      chk(16'h0000, 16'h0001);
      tally_and_finish;
    end
    got_data = host_rdata;
    got_ref = host_refused;
    got_hit = host_hit;
  endtask

  task put_step(input logic [6:0] idx, input logic [13:0] tgt, input logic [7:0] val, input logic [2:0] cnt,
                input logic [3:0] pos, input logic [3:0] wt, input logic last);
    logic [14:0] b;
    b = 15'h1000 + {6'h00, idx, 2'b00};
    cmd(1'b1, b, {2'h0, tgt});
    cmd(1'b1, b + 15'h0001, {8'h00, val});
    cmd(1'b1, b + 15'h0002, {5'h00, cnt, 4'h0, pos});
    cmd(1'b1, b + 15'h0003, {7'h00, last, 4'h0, wt});
    cmd(1'b0, b + 15'h0002, 16'h0000);
    chk(got_data, {5'h00, cnt, 4'h0, pos});
  endtask

  // Bounded wait for the next finished event
  task wait_fin(input int f0);
    int n;
    n = 0;
    while (fin_cnt == f0 && n < 400) begin
      @(negedge mclk);
      n++;
    end
    if (fin_cnt == f0) begin
      chk(16'h0000, 16'h0001);
      tally_and_finish;
    end
  endtask

  initial begin
    int f0;
    rst = 1'b1;
    host_req = 1'b0;
    host_we = 1'b0;
    host_addr = 15'h0000;
    host_wdata = 16'h0000;
    int_rate_mode = 1'b1;
    dac_automute = 1'b0;
    repeat (6) @(negedge mclk);
    rst = 1'b0;
    // Defaults of the three control registers, plus an unmapped read
    cmd(1'b0, 15'h0057, 16'h0000);
    chk(got_data, 16'h0000);
    cmd(1'b0, 15'h005A, 16'h0000);
    chk(got_data, 16'h0000);
    cmd(1'b0, 15'h005D, 16'h0000);
    chk(got_data, 16'h0000);
    cmd(1'b0, 15'h1200, 16'h0000);
    chk({15'h0000, got_hit}, 16'h0000);
    $display("test reset done");
    // Launch while disabled is dropped
    cmd(1'b1, 15'h005A, 16'h0082);
    cmd(1'b0, 15'h005D, 16'h0000);
    chk(got_data, 16'h0000);
    chk(16'(nwr), 16'h0000);
    $display("test disabled launch done");
    // Program steps; the top step proves index 127 reaches 0x11FC
    put_step(7'h02, 14'h0005, 8'h03, 3'h1, 4'h1, 4'h0, 1'b0);
    put_step(7'h03, 14'h0006, 8'hFF, 3'h7, 4'hC, 4'h1, 1'b1);
    put_step(7'h00, 14'h0007, 8'h05, 3'h2, 4'h4, 4'h0, 1'b1);
    put_step(7'h10, 14'h0008, 8'h01, 3'h0, 4'hF, 4'h0, 1'b1);
    put_step(7'h7F, 14'h0009, 8'h01, 3'h0, 4'h0, 4'h0, 1'b1);
    // Two-step run from index 2 with refused accesses in mid-run
    f0 = fin_cnt;
    cmd(1'b1, 15'h0057, 16'h0020);
    cmd(1'b1, 15'h005A, 16'h0082);
    chk({15'h0000, seq_running_flag}, 16'h0001);
    cmd(1'b0, 15'h005D, 16'h0000);
    chk(got_data & 16'h0001, 16'h0001);
    cmd(1'b0, 15'h0010, 16'h0000);
    chk({15'h0000, got_ref}, 16'h0001);
    cmd(1'b1, 15'h1008, 16'h3FFF);
    chk({15'h0000, got_ref}, 16'h0001);
    cmd(1'b0, 15'h0000, 16'h0000);
    chk({15'h0000, got_ref}, 16'h0000);
    wait_fin(f0);
    chk({15'h0000, seq_running_flag}, 16'h0000);
    chk(16'(wr_gap), 16'd38);
    chk(model.regs[5], 16'h0006);
    chk(model.regs[6], 16'hF000);
    cmd(1'b0, 15'h005D, 16'h0000);
    chk(got_data, 16'h0018);
    cmd(1'b0, 15'h005A, 16'h0000);
    chk(got_data, 16'h0002);
    cmd(1'b0, 15'h1008, 16'h0000);
    chk(got_data, 16'h0005);
    chk({15'h0000, got_hit}, 16'h0001);
    $display("test run done");
    // Cancel during the wait of a fractional-rate step
    int_rate_mode = 1'b0;
    f0 = wr_cyc;
    cmd(1'b1, 15'h005A, 16'h0083);
    while (wr_cyc == f0 && cyc < 20000) @(negedge mclk);
    if (wr_cyc == f0) begin
      chk(16'h0000, 16'h0001);
      tally_and_finish;
    end
    f0 = fin_cnt;
    cmd(1'b1, 15'h005A, 16'h0100);
    cmd(1'b0, 15'h005D, 16'h0000);
    chk(got_data, 16'h0018);
    cmd(1'b0, 15'h005A, 16'h0000);
    chk(got_data & 16'h0080, 16'h0000);
    repeat (60) @(negedge mclk);
    chk(16'(fin_cnt - f0), 16'h0000);
    $display("test cancel done");
    // Dropping the unit enable mid-run also ends the sequence
    cmd(1'b1, 15'h005A, 16'h0083);
    chk({15'h0000, seq_running_flag}, 16'h0001);
    cmd(1'b1, 15'h0057, 16'h0000);
    chk({15'h0000, seq_running_flag}, 16'h0000);
    $display("test enable drop done");
    // Auto-mute runs the sleep steps, unmute the wake steps
    cmd(1'b1, 15'h0057, 16'h00A0);
    f0 = fin_cnt;
    dac_automute = 1'b1;
    wait_fin(f0);
    chk(model.regs[7], 16'h0050);
    f0 = fin_cnt;
    dac_automute = 1'b0;
    wait_fin(f0);
    chk(model.regs[8], 16'h8000);
    $display("test auto sequence done");
    tally_and_finish;
  end
endmodule // control_write_sequencer_test
